/* File: rtcc_pkg.sv */
// constants and types shared by the clock control block
package rtcc_pkg;
  localparam int unsigned RTCC_ADR_W = 8;
  localparam int unsigned RTCC_DAT_W = 32;
  localparam int unsigned RTCC_TMR_W = 32;
  localparam int unsigned RTCC_BYTES = 4;

  // register indices; byte address is four times the index
  localparam logic [3:0] RTCC_IDX_CAP0 = 4'h0;
  localparam logic [3:0] RTCC_IDX_CTRL = 4'h4;
  localparam logic [3:0] RTCC_IDX_ALM0 = 4'h8;

  // rtc_control field positions
  localparam int unsigned RTCC_B_OSC_EN = 7;
  localparam int unsigned RTCC_B_MCD_EN = 6;
  localparam int unsigned RTCC_B_FAIL = 5;
  localparam int unsigned RTCC_B_RUN = 4;
  localparam int unsigned RTCC_B_AEN = 3;
  localparam int unsigned RTCC_B_ALARM_FLAG_AUTORESET = 2;
  localparam int unsigned RTCC_B_LOAD = 1;
  localparam int unsigned RTCC_B_SNAP = 0;

  // reset values
  localparam logic [7:0] RTCC_CTRL_RST = 8'h00;
  localparam logic [31:0] RTCC_TMR_RST = 32'h0000_0000;
  localparam logic [7:0] RTCC_BYTE_RST = 8'h00;

  // missing clock limit: 100 us at a 40 ns clock
  localparam int unsigned RTCC_CLK_PERIOD_NS = 40;
  localparam int unsigned RTCC_MCD_LIMIT_NS = 100000;
  localparam int unsigned RTCC_MCD_LIMIT_CYC =
    (RTCC_MCD_LIMIT_NS + RTCC_CLK_PERIOD_NS - 1) / RTCC_CLK_PERIOD_NS;
  localparam int unsigned RTCC_MCD_CNT_W = 16;

  typedef enum logic [1:0] {
    RTCC_XFER_IDLE = 2'b00,
    RTCC_XFER_BUSY = 2'b01,
    RTCC_XFER_DONE = 2'b10
  } rtcc_xfer_t;
endpackage : rtcc_pkg

/* File: rtcc_core_if.sv */
// signals between the control registers, the timer and the detector
`timescale 1ns/100ps
interface rtcc_core_if;
  import rtcc_pkg::*;
  logic tick;
  logic run;
  logic alarm_en;
  logic auto_reset;
  logic load_req;
  logic snap_req;
  logic [RTCC_TMR_W-1:0] load_val;
  logic [RTCC_TMR_W-1:0] alarm_val;
  logic [RTCC_TMR_W-1:0] count;
  logic alarm_flag;
  logic load_done;
  logic snap_done;
  logic osc_level;
  logic mcd_en;
  logic fail_evt;

  modport ctrl (
    output tick, run, alarm_en, auto_reset, load_req, snap_req,
    output load_val, alarm_val, osc_level, mcd_en,
    input count, alarm_flag, load_done, snap_done, fail_evt
  );
  modport timer (
    input tick, run, alarm_en, auto_reset, load_req, snap_req,
    input load_val, alarm_val,
    output count, alarm_flag, load_done, snap_done
  );
  modport mcd (
    input osc_level, mcd_en,
    output fail_evt
  );
endinterface : rtcc_core_if

/* File: rtcc_timer.sv */
// 32-bit timer with alarm compare, auto reset, load and snapshot
`timescale 1ns/100ps
module rtcc_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  rtcc_core_if.timer tif
);
  import rtcc_pkg::*;

  logic [RTCC_TMR_W-1:0] count_q;
  logic alarm_q;
  logic load_done_q;
  logic snap_done_q;
  logic do_load;

  assign do_load = tif.load_req && !load_done_q;

  // load wins over counting, so the timer need not be stopped first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= RTCC_TMR_RST;
    end else if (do_load) begin
      count_q <= tif.load_val;
    end else if (tif.tick && tif.run) begin
      if (alarm_q && tif.auto_reset) begin
        count_q <= RTCC_TMR_RST;
      end else begin
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  // flag rises on the tick that reaches the alarm value, falls on the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_q <= 1'b0;
    end else if (!tif.alarm_en) begin
      alarm_q <= 1'b0;
    end else if (tif.tick && tif.run) begin
      alarm_q <= !do_load && !(alarm_q && tif.auto_reset) &&
        (count_q + 32'h0000_0001 == tif.alarm_val);
    end else if (tif.tick) begin
      alarm_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_done_q <= 1'b0;
    end else begin
      load_done_q <= do_load;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_done_q <= 1'b0;
    end else begin
      snap_done_q <= tif.snap_req && !snap_done_q;
    end
  end

  assign tif.count = count_q;
  assign tif.alarm_flag = alarm_q;
  assign tif.load_done = load_done_q;
  assign tif.snap_done = snap_done_q;
endmodule : rtcc_timer

/* File: rtcc_mcd.sv */
// missing slow clock detector: a level held too long raises one event
`timescale 1ns/100ps
module rtcc_mcd #(
  parameter int unsigned LIMIT_CYC = rtcc_pkg::RTCC_MCD_LIMIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  rtcc_core_if.mcd mif
);
  import rtcc_pkg::*;

  logic [RTCC_MCD_CNT_W-1:0] cnt_q;
  logic last_q;
  logic fired_q;
  logic hit;

  assign hit = cnt_q >= LIMIT_CYC[RTCC_MCD_CNT_W-1:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_q <= 1'b0;
    end else begin
      last_q <= mif.osc_level;
    end
  end

  // one-shot: counts stop at the limit until the level moves again
  always_ff @(posedge clk_i) begin
    if (rst_i || !mif.mcd_en || last_q != mif.osc_level) begin
      cnt_q <= '0;
    end else if (!hit) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !mif.mcd_en || last_q != mif.osc_level) begin
      fired_q <= 1'b0;
    end else if (hit) begin
      fired_q <= 1'b1;
    end
  end

  assign mif.fail_evt = hit && !fired_q && mif.mcd_en;
endmodule : rtcc_mcd

/* File: rtcc_top.sv */
// clock control register block with wishbone slave, timer and detector
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
module rtcc_top #(
  parameter int unsigned MCD_LIMIT_CYC = rtcc_pkg::RTCC_MCD_LIMIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [rtcc_pkg::RTCC_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [rtcc_pkg::RTCC_DAT_W-1:0] dat_i,
  output logic [rtcc_pkg::RTCC_DAT_W-1:0] dat_o,
  output logic ack_o,
  input wire logic slow_osc_i,
  output logic slow_osc_enable_o,
  output logic [rtcc_pkg::RTCC_TMR_W-1:0] timer_count_o,
  output logic alarm_event_o
);
  import rtcc_pkg::*;

  rtcc_core_if cif ();

  // bus decode
  logic req;
  logic wr_now;
  logic lane0;
  logic [3:0] idx;
  logic in_map;
  logic sel_ctrl;
  logic sel_cap;
  logic sel_alm;
  logic ack_q;
  logic [RTCC_DAT_W-1:0] rdat_q;
  logic [7:0] rbyte;
  logic [7:0] wbyte;

  // control state
  logic osc_en_q;
  logic mcd_en_q;
  logic fail_q;
  logic run_q;
  logic aen_q;
  logic autorst_q;
  logic load_q;
  logic snap_q;
  rtcc_xfer_t load_st_q;
  rtcc_xfer_t snap_st_q;

  // capture and alarm bytes
  logic [RTCC_TMR_W-1:0] cap_q;
  logic [RTCC_TMR_W-1:0] alm_q;

  // slow oscillator pin synchroniser
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic osc_lvl_q;
  logic osc_rise;

  assign req = cyc_i && stb_i;
  assign wr_now = req && we_i && ack_q;
  assign lane0 = sel_i[0];
  assign idx = adr_i[5:2];
  assign in_map = (adr_i[7:6] == 2'b00) && (adr_i[1:0] == 2'b00);
  assign sel_ctrl = in_map && (idx == RTCC_IDX_CTRL);
  assign sel_cap = in_map && (idx >= RTCC_IDX_CAP0) &&
    (idx < RTCC_IDX_CAP0 + 4'h4);
  assign sel_alm = in_map && (idx >= RTCC_IDX_ALM0) &&
    (idx < RTCC_IDX_ALM0 + 4'h4);
  assign wbyte = dat_i[7:0];

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_comb begin
    rbyte = 8'h00;
    if (sel_ctrl) begin
      rbyte[RTCC_B_OSC_EN] = osc_en_q;
      rbyte[RTCC_B_MCD_EN] = mcd_en_q;
      // undefined while off; reads as zero then
      rbyte[RTCC_B_FAIL] = fail_q && osc_en_q;
      rbyte[RTCC_B_RUN] = run_q;
      rbyte[RTCC_B_AEN] = aen_q;
      rbyte[RTCC_B_ALARM_FLAG_AUTORESET] = cif.alarm_flag;
      rbyte[RTCC_B_LOAD] = load_q;
      rbyte[RTCC_B_SNAP] = snap_q;
    end else if (sel_cap) begin
      rbyte = cap_q[8*(idx-RTCC_IDX_CAP0) +: 8];
    end else if (sel_alm) begin
      rbyte = alm_q[8*(idx-RTCC_IDX_ALM0) +: 8];
    end
  end

  // unmapped reads answer zero; upper bits always zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= '0;
    end else if (req && !ack_q) begin
      rdat_q <= {24'h00_0000, rbyte};
    end
  end

  assign dat_o = rdat_q;
  assign ack_o = ack_q;

  // oscillator pin: a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= slow_osc_i;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_lvl_q <= 1'b0;
    end else if (osc_s2_q == osc_s3_q) begin
      osc_lvl_q <= osc_s3_q;
    end
  end

  assign osc_rise = (osc_s2_q == osc_s3_q) && osc_s3_q && !osc_lvl_q;

  // oscillator enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_en_q <= RTCC_CTRL_RST[RTCC_B_OSC_EN];
    end else if (wr_now && sel_ctrl && lane0) begin
      osc_en_q <= wbyte[RTCC_B_OSC_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mcd_en_q <= RTCC_CTRL_RST[RTCC_B_MCD_EN];
    end else if (wr_now && sel_ctrl && lane0) begin
      mcd_en_q <= wbyte[RTCC_B_MCD_EN];
    end
  end

  // fail flag: set beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_q <= 1'b0;
    end else if (cif.fail_evt) begin
      fail_q <= 1'b1;
    end else if (wr_now && sel_ctrl && lane0 && !wbyte[RTCC_B_FAIL]) begin
      fail_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= RTCC_CTRL_RST[RTCC_B_RUN];
    end else if (wr_now && sel_ctrl && lane0) begin
      run_q <= wbyte[RTCC_B_RUN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aen_q <= RTCC_CTRL_RST[RTCC_B_AEN];
    end else if (wr_now && sel_ctrl && lane0) begin
      aen_q <= wbyte[RTCC_B_AEN];
    end
  end

  // write side of bit 2 lands here, never on the event flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      autorst_q <= RTCC_CTRL_RST[RTCC_B_ALARM_FLAG_AUTORESET];
    end else if (wr_now && sel_ctrl && lane0) begin
      autorst_q <= wbyte[RTCC_B_ALARM_FLAG_AUTORESET];
    end
  end

  // load request: writing zero does not abort a load in flight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_q <= RTCC_CTRL_RST[RTCC_B_LOAD];
    end else if (load_st_q == RTCC_XFER_DONE) begin
      load_q <= 1'b0;
    end else if (wr_now && sel_ctrl && lane0 && wbyte[RTCC_B_LOAD]) begin
      load_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_q <= RTCC_CTRL_RST[RTCC_B_SNAP];
    end else if (snap_st_q == RTCC_XFER_DONE) begin
      snap_q <= 1'b0;
    end else if (wr_now && sel_ctrl && lane0 && wbyte[RTCC_B_SNAP]) begin
      snap_q <= 1'b1;
    end
  end

  // transfer sequencers: request, timer done, then clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_st_q <= RTCC_XFER_IDLE;
    end else begin
      unique case (load_st_q)
        RTCC_XFER_IDLE: begin
          if (load_q) begin
            load_st_q <= RTCC_XFER_BUSY;
          end
        end
        RTCC_XFER_BUSY: begin
          if (cif.load_done) begin
            load_st_q <= RTCC_XFER_DONE;
          end
        end
        RTCC_XFER_DONE: begin
          load_st_q <= RTCC_XFER_IDLE;
        end
        default: begin
          load_st_q <= RTCC_XFER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_st_q <= RTCC_XFER_IDLE;
    end else begin
      unique case (snap_st_q)
        RTCC_XFER_IDLE: begin
          if (snap_q) begin
            snap_st_q <= RTCC_XFER_BUSY;
          end
        end
        RTCC_XFER_BUSY: begin
          if (cif.snap_done) begin
            snap_st_q <= RTCC_XFER_DONE;
          end
        end
        RTCC_XFER_DONE: begin
          snap_st_q <= RTCC_XFER_IDLE;
        end
        default: begin
          snap_st_q <= RTCC_XFER_IDLE;
        end
      endcase
    end
  end

  // capture and alarm bytes; the snapshot wins over a bus write
  genvar b;
  generate
    for (b = 0; b < RTCC_BYTES; b++) begin : g_byte
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cap_q[8*b +: 8] <= RTCC_BYTE_RST;
        end else if (snap_st_q == RTCC_XFER_BUSY && cif.snap_done) begin
          cap_q[8*b +: 8] <= cif.count[8*b +: 8];
        end else if (wr_now && lane0 && in_map &&
            idx == RTCC_IDX_CAP0 + 4'(b)) begin
          cap_q[8*b +: 8] <= wbyte;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          alm_q[8*b +: 8] <= RTCC_BYTE_RST;
        end else if (wr_now && lane0 && in_map &&
            idx == RTCC_IDX_ALM0 + 4'(b)) begin
          alm_q[8*b +: 8] <= wbyte;
        end
      end
    end
  endgenerate

  // core connections; a stopped oscillator gives no ticks
  assign cif.tick = osc_rise && osc_en_q;
  assign cif.run = run_q;
  assign cif.alarm_en = aen_q;
  assign cif.auto_reset = autorst_q;
  assign cif.load_req = load_st_q == RTCC_XFER_BUSY;
  assign cif.snap_req = snap_st_q == RTCC_XFER_BUSY;
  assign cif.load_val = cap_q;
  assign cif.alarm_val = alm_q;
  assign cif.osc_level = osc_lvl_q;
  assign cif.mcd_en = mcd_en_q && osc_en_q;

  rtcc_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tif(cif.timer)
  );

  rtcc_mcd #(
    .LIMIT_CYC(MCD_LIMIT_CYC)
  ) u_mcd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mif(cif.mcd)
  );

  assign slow_osc_enable_o = osc_en_q;
  assign timer_count_o = cif.count;
  assign alarm_event_o = cif.alarm_flag;
endmodule : rtcc_top

/* File: rtcc_monitor.sv */
// port checks for the clock control register block
`timescale 1ns/100ps
module rtcc_monitor #(
  parameter int unsigned MCD_LIMIT_CYC = rtcc_pkg::RTCC_MCD_LIMIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [rtcc_pkg::RTCC_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [rtcc_pkg::RTCC_DAT_W-1:0] dat_i,
  input wire logic [rtcc_pkg::RTCC_DAT_W-1:0] dat_o,
  input wire logic ack_o,
  input wire logic slow_osc_i,
  input wire logic slow_osc_enable_o,
  input wire logic [rtcc_pkg::RTCC_TMR_W-1:0] timer_count_o,
  input wire logic alarm_event_o
);
  import rtcc_pkg::*;
  logic wr_any, wr_ctrl, wr_alm, osc_q, run_q, aen_q;
  logic [3:0] ld_age_q;
  logic [31:0] alm_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign wr_any = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  assign wr_ctrl = wr_any && adr_i == 8'h10;
  assign wr_alm = wr_any && adr_i[7:4] == 4'h2 && adr_i[1:0] == 2'h0;
  // shadows of written control bits; the bus is their only cause
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_q <= 1'b0;
      run_q <= 1'b0;
      aen_q <= 1'b0;
    end else if (wr_ctrl) begin
      osc_q <= dat_i[7];
      run_q <= dat_i[4];
      aen_q <= dat_i[3];
    end
  end
  // age of the last load request; saturates so old loads stop mattering
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ld_age_q <= 4'hf;
    end else if (wr_ctrl && dat_i[1]) begin
      ld_age_q <= 4'h0;
    end else if (ld_age_q != 4'hf) begin
      ld_age_q <= ld_age_q + 4'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alm_q <= 32'h0;
    end else if (wr_alm) begin
      alm_q[adr_i[3:2]*8 +: 8] <= dat_i[7:0];
    end
  end
  a_ack_pulse: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack is not one pulse after the request");
  a_osc_follow: assert property (
    wr_ctrl |=> ##[0:1] slow_osc_enable_o == osc_q)
    else $error("oscillator enable differs from written bit");
  a_osc_cause: assert property (
    $changed(slow_osc_enable_o) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
    else $error("oscillator enable moved without a write");
  a_count_step: assert property (
    ld_age_q == 4'hf && $changed(timer_count_o) |->
      timer_count_o == $past(timer_count_o) + 32'h1 || timer_count_o == 0)
    else $error("timer jumped by more than one");
  a_hold_stop: assert property (
    (!run_q)[*6] ##1 (!run_q && ld_age_q == 4'hf) |-> $stable(timer_count_o))
    else $error("stopped timer changed");
  a_alarm_gate: assert property ($rose(alarm_event_o) |-> $past(aen_q))
    else $error("alarm while alarms disabled");
  a_alarm_match: assert property (
    $rose(alarm_event_o) |-> ##[0:1] timer_count_o == alm_q)
    else $error("alarm without count match");
  a_alarm_short: assert property (
    $rose(alarm_event_o) |-> ##[1:10] !alarm_event_o)
    else $error("alarm flag held too long");
  a_alarm_clear: assert property (
    wr_ctrl && !dat_i[3] |-> ##[1:2] !alarm_event_o)
    else $error("alarm flag kept after disable");
  a_fail_read: assert property (
    ack_o && cyc_i && stb_i && !we_i && adr_i == 8'h10 |->
      dat_o[7] == slow_osc_enable_o && (slow_osc_enable_o || !dat_o[5]))
    else $error("control readback wrong for oscillator state");
  c_alarm: cover property ($rose(alarm_event_o));
  c_load: cover property (wr_ctrl && dat_i[1]);
  c_clear: cover property (wr_ctrl && !dat_i[3] && alarm_event_o);
endmodule : rtcc_monitor

bind rtcc_top rtcc_monitor #(.MCD_LIMIT_CYC(MCD_LIMIT_CYC)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .slow_osc_i(slow_osc_i), .slow_osc_enable_o(slow_osc_enable_o),
  .timer_count_o(timer_count_o), .alarm_event_o(alarm_event_o));

/* File: rtcc_tb_top.sv */
// self-checking bench for the clock control register block
`timescale 1ns/100ps
module rtcc_tb_top;
  import rtcc_pkg::*;
  localparam int unsigned LIM = 20;
  logic clk, rst, cyc, stb, we, ack, slow_osc, osc_en, alarm, osc_run;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [2:0] div;
  logic [31:0] wdat, dout, rdat, cnt, v, base;
  int err_total;
  int n_checks;

  rtcc_top #(.MCD_LIMIT_CYC(LIM)) u_dut (.clk_i(clk), .rst_i(rst),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(dout), .ack_o(ack), .slow_osc_i(slow_osc),
    .slow_osc_enable_o(osc_en), .timer_count_o(cnt),
    .alarm_event_o(alarm));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // slow clock of eight cycles; halting it mimics a dead crystal
  always @(posedge clk) begin
    if (rst) begin
      div <= 3'h0;
      slow_osc <= 1'b0;
    end else if (osc_run) begin
      div <= div + 3'h1;
      slow_osc <= div[2];
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // waits for ack however long it takes; the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [7:0] d, input logic [3:0] s);
    @(posedge clk);
    {cyc, stb, we, adr, sel} <= {2'b11, w, a, s};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dout;
    {cyc, stb} <= 2'b00;
    chk(dout & 32'hffff_ff00, 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h0, 4'h1);
  endtask : rd

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    for (int k = 0; k < 4; k++) begin
      wr(a + 8'(4 * k), d[8*k +: 8]);
    end
  endtask : wr32

  // reads control until the given request bit has cleared
  task automatic poll(input int b);
    for (int i = 0; i < 30; i++) begin
      rd(8'h10);
      if (rdat[b] === 1'b0) break;
    end
  endtask : poll

  task automatic wait_lvl(input logic l);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      if (alarm === l) break;
    end
  endtask : wait_lvl

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    osc_run = 1'b1;
    err_total = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(8'h10);
    chk(rdat, 32'h0);
    wr(8'h40, 8'hff);
    rd(8'h40);
    chk(rdat, 32'h0);
    bus(1'b1, 8'h00, 8'h5a, 4'he);
    rd(8'h00);
    chk(rdat, 32'h0);
    wr32(8'h00, 32'h1234_5678);
    wr(8'h10, 8'h82);
    poll(1);
    chk(rdat & 32'h2, 32'h0);
    chk(cnt, 32'h1234_5678);
    chk({31'h0, osc_en}, 32'h1);
    wr(8'h10, 8'h90);
    base = cnt;
    repeat (80) @(posedge clk);
    chk({31'h0, cnt - base >= 32'h9 && cnt - base <= 32'hb}, 32'h1);
    // load while counting: the timer must not need stopping
    wr32(8'h00, 32'h100);
    wr(8'h10, 8'h92);
    poll(1);
    chk({31'h0, cnt - 32'h100 < 32'h4}, 32'h1);
    wr(8'h10, 8'h80);
    repeat (8) @(posedge clk);
    base = cnt;
    repeat (40) @(posedge clk);
    chk(cnt, base);
    wr(8'h10, 8'h81);
    poll(0);
    chk(rdat & 32'h1, 32'h0);
    v = 32'h0;
    for (int k = 0; k < 4; k++) begin
      rd(8'(4 * k));
      v[8*k +: 8] = rdat[7:0];
    end
    chk(v, cnt);
    wr32(8'h20, v + 32'h3);
    wr(8'h10, 8'h9c);
    rd(8'h10);
    chk(rdat, 32'h98);
    wait_lvl(1'b1);
    @(posedge clk);
    chk(cnt, v + 32'h3);
    rd(8'h10);
    chk(rdat & 32'h4, 32'h4);
    wait_lvl(1'b0);
    @(posedge clk);
    chk(cnt, 32'h0);
    wr32(8'h20, 32'h8);
    wait_lvl(1'b1);
    wr(8'h10, 8'h94);
    repeat (2) @(posedge clk);
    chk({31'h0, alarm}, 32'h0);
    wr(8'h10, 8'hc0);
    repeat (40) @(posedge clk);
    rd(8'h10);
    chk(rdat, 32'hc0);
    osc_run <= 1'b0;
    repeat (40) @(posedge clk);
    rd(8'h10);
    chk(rdat, 32'he0);
    wr(8'h10, 8'hc0);
    rd(8'h10);
    chk(rdat, 32'hc0);
    // a second stall after the level moved again must re-arm the one-shot
    osc_run <= 1'b1;
    repeat (16) @(posedge clk);
    osc_run <= 1'b0;
    repeat (40) @(posedge clk);
    rd(8'h10);
    chk(rdat, 32'he0);
    // oscillator off with the flag still set: fail bit must read zero
    wr(8'h10, 8'h60);
    rd(8'h10);
    chk(rdat, 32'h40);
    chk({31'h0, osc_en}, 32'h0);
    complete_run();
  end
endmodule : rtcc_tb_top
